// [design/coherent_load_pkg.sv]
// package of offsets, field positions and reset values, plus the shadow byte cell
// assumes one bus clock shared with the counter and an active-low reset already synchronised
`timescale 1ns/1ps
`default_nettype none

package coherent_load_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] LOAD_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] COUNT_OFFSET = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PERIODIC_BIT = 1;
   localparam logic CTRL_EN_RESET = 1'b0;
   localparam logic CTRL_PERIODIC_RESET = 1'b0;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam int WORD_BYTES = 4;
   localparam int BYTE_W = 8;
endpackage : coherent_load_pkg

module shadow_byte
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // byte write
   input wire logic write_i,
   input wire logic [WIDTH-1:0] data_i,
   output logic [WIDTH-1:0] data_o
);
   typedef struct packed
   {
      logic [WIDTH-1:0] value;
   } state_s;

   state_s state_reg;
   state_s state_next;

   always_comb
   begin
      state_next = state_reg;
      if (write_i)
      begin
         state_next.value = data_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg.value <= RESET_VALUE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign data_o = state_reg.value;
endmodule : shadow_byte

`default_nettype wire

// [design/apb_coherent_load_register.sv]
// apb slave with coherent load register, control register and load-driven down counter
// assumes an apb master on clock_i, the counter on the same clock, writes low byte first
`timescale 1ns/1ps
`default_nettype none

module apb_coherent_load_register
#(
   parameter int DATA_W = 8,
   parameter int LOAD_W = 32
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [coherent_load_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   // counter side
   output logic [LOAD_W-1:0] committed_load_value_o,
   output logic counter_load_strobe_o,
   output logic [LOAD_W-1:0] count_o,
   output logic expired_o
);
   localparam int WB = DATA_W / coherent_load_pkg::BYTE_W;
   localparam int UB = (LOAD_W - 1) / coherent_load_pkg::BYTE_W;
   // lane bits that still pick a byte at this bus width
   localparam logic [1:0] LANE_MASK = 2'(coherent_load_pkg::WORD_BYTES - WB);
   // registers sit on word boundaries, the low address bits only select a lane
   localparam int LANE_W = 2;

   typedef struct packed
   {
      logic [DATA_W-1:0] rdata;
      logic [LOAD_W-1:0] load;
      logic strobe;
      logic [LOAD_W-1:0] count;
      logic en;
      logic periodic;
      logic expired;
   } state_s;

   state_s state_reg;
   state_s state_next;
   logic rst_meta_reg;
   logic rst_n;

   // release of the async reset through two flops
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   logic [5:0] word_addr;
   logic [1:0] lane_sel;
   logic [4:0] bit_off;
   logic wr_access;
   logic rd_setup;
   logic wr_load;
   logic wr_ctrl;
   logic rd_load;
   logic rd_ctrl;
   logic rd_count;
   logic [3:0] byte_we;
   logic [7:0] wbyte [4];
   logic [7:0] shadow [4];
   logic commit;
   logic [31:0] commit_word;
   logic [31:0] rd_word;

   assign word_addr = paddr_i[coherent_load_pkg::ADDR_W-1:LANE_W];
   assign lane_sel = paddr_i[LANE_W-1:0] & LANE_MASK;
   assign bit_off = {lane_sel, 3'b000};
   assign wr_access = psel_i && pwrite_i && penable_i;
   assign rd_setup = psel_i && !pwrite_i && !penable_i;
   assign wr_load = wr_access && (word_addr == coherent_load_pkg::LOAD_OFFSET[coherent_load_pkg::ADDR_W-1:LANE_W]);
   assign wr_ctrl = wr_access && (word_addr == coherent_load_pkg::CTRL_OFFSET[coherent_load_pkg::ADDR_W-1:LANE_W]);
   assign rd_load = rd_setup && (word_addr == coherent_load_pkg::LOAD_OFFSET[coherent_load_pkg::ADDR_W-1:LANE_W]);
   assign rd_ctrl = rd_setup && (word_addr == coherent_load_pkg::CTRL_OFFSET[coherent_load_pkg::ADDR_W-1:LANE_W]);
   assign rd_count = rd_setup && (word_addr == coherent_load_pkg::COUNT_OFFSET[coherent_load_pkg::ADDR_W-1:LANE_W]);

   genvar k;
   generate
      for (k = 0; k < 4; k++)
      begin : g_lane
         // lane picked by the low address bits on narrow buses
         assign wbyte[k] = pwdata_i[(k % WB) * 8 +: 8];
         if (k <= UB)
         begin : g_used
            assign byte_we[k] = wr_load && ((2'(k) & LANE_MASK) == lane_sel);
         end
         else
         begin : g_unused
            // bits above the register width are dropped
            assign byte_we[k] = 1'b0;
         end
         if (k < UB)
         begin : g_shadow
            // bytes below the upper byte wait here; never built when load fits in one byte
            shadow_byte #(
               .WIDTH(8),
               .RESET_VALUE(coherent_load_pkg::SHADOW_RESET)
            ) u_shadow (
               .clock_i(clock_i),
               .rst_n_i(rst_n),
               .write_i(byte_we[k]),
               .data_i(wbyte[k]),
               .data_o(shadow[k])
            );
            assign commit_word[k*8 +: 8] = byte_we[k] ? wbyte[k] : shadow[k];
         end
         else
         begin : g_direct
            assign shadow[k] = 8'h00;
            assign commit_word[k*8 +: 8] = (k == UB) ? wbyte[k] : 8'h00;
         end
      end
   endgenerate

   // commit on the write that carries the upper byte
   assign commit = byte_we[UB];

   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (rd_load)
      begin
         rd_word = 32'(state_reg.load);
      end
      else if (rd_ctrl)
      begin
         rd_word[coherent_load_pkg::CTRL_EN_BIT] = state_reg.en;
         rd_word[coherent_load_pkg::CTRL_PERIODIC_BIT] = state_reg.periodic;
      end
      else if (rd_count)
      begin
         rd_word = 32'(state_reg.count);
      end
   end

   always_comb
   begin
      state_next = state_reg;
      state_next.strobe = 1'b0;
      state_next.expired = 1'b0;
      // unmapped reads capture zero rather than hold
      if (rd_setup)
      begin
         state_next.rdata = rd_word[bit_off +: DATA_W];
      end
      if (commit)
      begin
         state_next.load = commit_word[LOAD_W-1:0];
         state_next.strobe = 1'b1;
      end
      // control bits all sit in byte 0, so other lanes of the word are dropped
      if (wr_ctrl && lane_sel == '0)
      begin
         state_next.en = pwdata_i[coherent_load_pkg::CTRL_EN_BIT];
         state_next.periodic = pwdata_i[coherent_load_pkg::CTRL_PERIODIC_BIT];
      end
      // the strobe wins over counting so a new value is never skipped
      if (state_reg.strobe)
      begin
         state_next.count = state_reg.load;
      end
      else if (state_reg.en)
      begin
         if (state_reg.count == '0)
         begin
            state_next.expired = 1'b1;
            if (state_reg.periodic)
            begin
               state_next.count = state_reg.load;
            end
         end
         else
         begin
            state_next.count = state_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg.rdata <= '0;
         state_reg.load <= '0;
         state_reg.strobe <= 1'b0;
         state_reg.count <= '0;
         state_reg.en <= coherent_load_pkg::CTRL_EN_RESET;
         state_reg.periodic <= coherent_load_pkg::CTRL_PERIODIC_RESET;
         state_reg.expired <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign prdata_o = state_reg.rdata;
   assign committed_load_value_o = state_reg.load;
   assign counter_load_strobe_o = state_reg.strobe;
   assign count_o = state_reg.count;
   assign expired_o = state_reg.expired;

   // bus decode and read path
   a_write_decode: assert property (@(posedge clock_i) disable iff (!rst_n)
      (|byte_we) |-> (psel_i && pwrite_i && penable_i))
      else $error("byte write outside access phase");

   a_setup_no_write: assert property (@(posedge clock_i) disable iff (!rst_n)
      (psel_i && pwrite_i && !penable_i) |=> ($stable(committed_load_value_o) && !counter_load_strobe_o))
      else $error("write acted in setup phase");

   a_read_capture: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_setup && rd_ctrl) |=> (prdata_o[coherent_load_pkg::CTRL_EN_BIT] == $past(state_reg.en) || lane_sel != 2'b00))
      else $error("read data not captured");

   a_count_read: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_count && lane_sel == '0) |=> (prdata_o == DATA_W'($past(count_o))))
      else $error("count read data wrong");

   a_read_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
      !rd_setup |=> $stable(prdata_o))
      else $error("read data moved without read");

   a_unmapped_zero: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_setup && !rd_load && !rd_ctrl && !rd_count) |=> (prdata_o == '0))
      else $error("unmapped read not zero");

   // coherent commit and counter
   a_shadow_holds: assert property (@(posedge clock_i) disable iff (!rst_n)
      (wr_load && !byte_we[UB]) |=> ($stable(committed_load_value_o) && !counter_load_strobe_o))
      else $error("lower byte changed committed value");

   a_commit_strobe: assert property (@(posedge clock_i) disable iff (!rst_n)
      commit |=> (counter_load_strobe_o && committed_load_value_o == $past(commit_word[LOAD_W-1:0])) ##1
      !counter_load_strobe_o)
      else $error("commit did not pulse strobe once");

   a_strobe_loads: assert property (@(posedge clock_i) disable iff (!rst_n)
      counter_load_strobe_o |=> (count_o == $past(committed_load_value_o)))
      else $error("counter not loaded on strobe");

   a_periodic_reload: assert property (@(posedge clock_i) disable iff (!rst_n)
      (!state_reg.strobe && state_reg.en && state_reg.periodic && count_o == '0)
      |=> (count_o == $past(committed_load_value_o) && expired_o)) else $error("periodic reload missed");

   // control register, lanes and reset
   a_ctrl_write: assert property (@(posedge clock_i) disable iff (!rst_n)
      (wr_ctrl && lane_sel == '0) |=> (state_reg.en == $past(pwdata_i[coherent_load_pkg::CTRL_EN_BIT])))
      else $error("control write not taken");

   a_ctrl_lanes: assert property (@(posedge clock_i) disable iff (!rst_n)
      (wr_ctrl && lane_sel != '0) |=> ($stable(state_reg.en) && $stable(state_reg.periodic)))
      else $error("control changed by an unused lane");

   a_lane_count: assert property (@(posedge clock_i) disable iff (!rst_n)
      (|byte_we) |-> ($countones(byte_we) <= WB))
      else $error("more byte lanes written than the bus carries");

   a_reset_clear: assert property (@(posedge clock_i)
      !rst_n |-> (committed_load_value_o == '0 && count_o == '0 && !counter_load_strobe_o))
      else $error("state not cleared in reset");
endmodule : apb_coherent_load_register

`default_nettype wire

// [tb/apb_bridge_model.sv]
// bus master model: issues two-cycle apb frames towards the slave
// assumes the slave samples everything on the rising edge of clock_i
`timescale 1ns/1ps
`default_nettype none

module apb_bridge_model
#(
   parameter int DATA_W = 8
)
(
   // clock
   input wire logic clock_i,
   // apb master side
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [coherent_load_pkg::ADDR_W-1:0] paddr_o,
   output logic [DATA_W-1:0] pwdata_o,
   input wire logic [DATA_W-1:0] prdata_i
);
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end

   // one idle cycle between frames, so no line is driven twice in one step
   task automatic xfer(input logic wr, input logic [coherent_load_pkg::ADDR_W-1:0] addr,
                       input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
      @(posedge clock_i);
      #1;
      psel_o = 1'b1;
      pwrite_o = wr;
      paddr_o = addr;
      pwdata_o = wdata;
      @(posedge clock_i);
      #1;
      penable_o = 1'b1;
      @(posedge clock_i);
      rdata = prdata_i;
      #1;
      // released lines change, so a stale value never looks valid
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = ~wr;
      paddr_o = ~addr;
      pwdata_o = ~wdata;
   endtask : xfer
endmodule : apb_bridge_model

`default_nettype wire

// [tb/testbench.sv]
// self-checking bench: 8-bit bus, 32-bit load value, bridge model as master
// assumes the design package is compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_s;
   logic clock_i;
   logic rstn_i;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [7:0] pwdata;
   logic [7:0] prdata;
   logic [31:0] committed;
   logic strobe;
   logic [31:0] count;
   logic expired;
   logic [7:0] rd;
   logic hit0;
   logic reload;
   logic seen_exp;
   int n_fail;
   int checks;
   int cycles;
   row_s rows [12] = '{'{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
      '{1'b0, 8'h0c, 8'h00, 8'h00}, '{1'b0, 8'h40, 8'h00, 8'h00}, '{1'b1, 8'h04, 8'hff, 8'h00},
      '{1'b0, 8'h04, 8'h00, 8'h03}, '{1'b1, 8'h04, 8'h00, 8'h00}, '{1'b1, 8'h05, 8'hff, 8'h00},
      '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b1, 8'h08, 8'hff, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
      '{1'b0, 8'h05, 8'h00, 8'h00}};

   apb_coherent_load_register #(.DATA_W(8), .LOAD_W(32)) u_apb_coherent_load_register (
      .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .committed_load_value_o(committed),
      .counter_load_strobe_o(strobe), .count_o(count), .expired_o(expired));

   apb_bridge_model #(.DATA_W(8)) u_apb_bridge_model (
      .clock_i(clock_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata));

   always #25 clock_i = ~clock_i;

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      u_apb_bridge_model.xfer(1'b1, addr, data, rd);
   endtask : wr

   task automatic end_of_test();
      if (n_fail == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // hang guard, well above the roughly 130 cycles the run needs
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   initial
   begin
      clock_i = 1'b0;
      rstn_i = 1'b0;
      n_fail = 0;
      checks = 0;
      cycles = 0;
      repeat (3) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      repeat (6) @(posedge clock_i);
      foreach (rows[i])
      begin
         u_apb_bridge_model.xfer(rows[i].wr, rows[i].addr, rows[i].data, rd);
         if (!rows[i].wr)
            check("prdata", 32'(rows[i].exp), 32'(rd));
      end
      wr(8'h00, 8'h44);
      wr(8'h01, 8'h33);
      wr(8'h02, 8'h22);
      check("committed", 32'h0, committed);
      check("strobe", 32'h0, 32'(strobe));
      wr(8'h03, 8'h11);
      // strobe stands only in the cycle right after the upper byte's access edge
      check("committed", 32'h11223344, committed);
      check("strobe", 32'h1, 32'(strobe));
      @(posedge clock_i);
      #1;
      check("strobe", 32'h0, 32'(strobe));
      check("count", 32'h11223344, count);
      u_apb_bridge_model.xfer(1'b0, 8'h08, 8'h00, rd);
      check("prdata", 32'h44, 32'(rd));
      wr(8'h04, 8'h00);
      check("prdata", 32'h44, 32'(prdata));
      wr(8'h00, 8'h03);
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h03);
      hit0 = 1'b0;
      reload = 1'b0;
      seen_exp = 1'b0;
      // observe a few periods: must hit zero, flag it, and come back to the load value
      repeat (30)
      begin
         @(posedge clock_i);
         #1;
         if (count === 32'h0)
            hit0 = 1'b1;
         if (hit0 && count === 32'h3)
            reload = 1'b1;
         if (expired === 1'b1)
            seen_exp = 1'b1;
      end
      check("reload", 32'h1, 32'(reload));
      check("expired", 32'h1, 32'(seen_exp));
      wr(8'h00, 8'h05);
      check("committed", 32'h3, committed);
      wr(8'h04, 8'h00);
      @(posedge clock_i);
      #1;
      rstn_i = 1'b0;
      #5;
      check("committed", 32'h0, committed);
      check("count", 32'h0, count);
      @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      repeat (6) @(posedge clock_i);
      // lone upper byte exposes whether the shadows were cleared
      wr(8'h03, 8'haa);
      @(posedge clock_i);
      #1;
      check("committed", 32'haa000000, committed);
      end_of_test();
   end
endmodule : testbench

`default_nettype wire
